// [hw/timer_gate_defs.svh]
// Constants for the timer gate control block: offsets, bit positions,
// source codes and reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef TIMER_GATE_DEFS_SVH
`define TIMER_GATE_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define TG_OFS_CTRL   8'h00
`define TG_OFS_GATE   8'h04
`define TG_OFS_STAT   8'h08
`define TG_OFS_CLR    8'h0c
`define TG_OFS_IEN    8'h10

// ==========================================================
// Bit positions
`define TG_BIT_RUN      0
`define TG_BIT_GE       7
`define TG_BIT_POL      6
`define TG_BIT_GTM      5
`define TG_BIT_SPM      4
`define TG_BIT_GO       3
`define TG_BIT_GATE_LEVEL_STATUS     2
`define TG_BIT_GSS_MSB  1
`define TG_BIT_GSS_LSB  0
`define TG_BIT_FLAG     0

// ==========================================================
// Gate source codes
`define TG_GSS_PIN    2'h0
`define TG_GSS_OVF    2'h1
`define TG_GSS_CMPA   2'h2
`define TG_GSS_CMPB   2'h3

// ==========================================================
// Reset and idle values
`define TG_BYTE_ZERO  8'h00

`endif

// [hw/timer_gate_pkg.sv]
// Types shared by the timer gate control block.
// Assumes the constants header is included by the files that use bits.
package timer_gate_pkg;

    // ==========================================================
    // Single-pulse phase
    typedef enum logic {
        SP_IDLE,
        SP_OPEN
    } sp_phase_e;

    // ==========================================================
    // Front end state: gate history and toggle flip-flop
    typedef struct packed {
        logic prevPolar;
        logic toggleFf;
    } front_state_s;

    // ==========================================================
    // Control state of the top module
    typedef struct packed {
        logic       counterRunBit;
        logic       gateEnable;
        logic       gatePolarity;
        logic       gateToggleMode;
        logic       gateSinglePulseMode;
        logic       singlePulseAcquireStatus;
        logic [1:0] gateSourceSelect;
        sp_phase_e  phase;
        logic       prevMid;
        logic       gateEventFlag;
        logic       gateEventIrqEnable;
        logic       gateLevel;
        logic       countEnable;
        logic       irq;
        logic [7:0] rdData;
    } ctrl_state_s;

endpackage : timer_gate_pkg

// [hw/gate_front_if.sv]
// Interface between the gate controller and its front end.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface gate_front_if;
    logic [1:0] gateSourceSelect;
    logic       gatePolarity;
    logic       gateToggleMode;
    logic       counterRunBit;
    logic       gateMid;

    modport ctl (
        output gateSourceSelect,
        output gatePolarity,
        output gateToggleMode,
        output counterRunBit,
        input  gateMid
    );
    modport front (
        input  gateSourceSelect,
        input  gatePolarity,
        input  gateToggleMode,
        input  counterRunBit,
        output gateMid
    );
endinterface : gate_front_if

// [hw/gate_front.sv]
// Gate front end: source select, polarity and toggle flip-flop.
// Assumes gate sources are synchronous to clk.
`timescale 1ns/1ps
`include "timer_gate_defs.svh"
module gate_front
    import timer_gate_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       gatePin,
    input  wire logic       otherTimerOverflow,
    input  wire logic       comparatorASyncedOutput,
    input  wire logic       comparatorBSyncedOutput,
    gate_front_if.front     fe
);

    front_state_s r;
    front_state_s n;
    logic         selGate;
    logic         polar;
    logic         rise;

    // ==========================================================
    // Select, polarise and toggle
    always_comb begin
        n = r;
        case (fe.gateSourceSelect)
            `TG_GSS_PIN:  selGate = gatePin;
            `TG_GSS_OVF:  selGate = otherTimerOverflow;
            `TG_GSS_CMPA: selGate = comparatorASyncedOutput;
            default:      selGate = comparatorBSyncedOutput;
        endcase
        // Active level mapped to one so later stages see one sense
        polar = fe.gatePolarity ? selGate : ~selGate;
        rise  = polar & ~r.prevPolar;
        n.prevPolar = polar;
        if (!fe.counterRunBit || !fe.gateToggleMode) begin
            n.toggleFf = 1'b0;
        end else if (rise) begin
            n.toggleFf = ~r.toggleFf;
        end
        // Toggle flip-flop replaces the gate only in toggle mode
        fe.gateMid = fe.gateToggleMode ? r.toggleFf : polar;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Checks
    property p_toggle_flip;
        @(posedge clk) disable iff (!rst_n)
        (fe.counterRunBit && fe.gateToggleMode && rise)
            |=> (r.toggleFf != $past(r.toggleFf));
    endproperty
    a_toggle_flip: assert property (p_toggle_flip)
        else $error("toggle flip-flop missed a gate edge");

    property p_toggle_clear_mode;
        @(posedge clk) disable iff (!rst_n)
        !fe.gateToggleMode |=> !r.toggleFf;
    endproperty
    a_toggle_clear_mode: assert property (p_toggle_clear_mode)
        else $error("toggle flip-flop set with toggle mode off");

    property p_toggle_clear_run;
        @(posedge clk) disable iff (!rst_n)
        !fe.counterRunBit |=> !r.toggleFf;
    endproperty
    a_toggle_clear_run: assert property (p_toggle_clear_run)
        else $error("toggle flip-flop set while stopped");

endmodule : gate_front

// [hw/timer_gate_control.sv]
// Gate control for a 16-bit timer: register port, single-pulse
// acquisition, gate event interrupt and the count enable.
// Assumes a simple strobe register port and sources synchronous to clk.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "timer_gate_defs.svh"
module timer_gate_control
    import timer_gate_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStb,
    input  wire logic       rdStb,
    output logic      [7:0] rdData,
    input  wire logic       gatePin,
    input  wire logic       otherTimerOverflow,
    input  wire logic       comparatorASyncedOutput,
    input  wire logic       comparatorBSyncedOutput,
    output logic            countEnable,
    output logic            irq
);

    ctrl_state_s  r;
    ctrl_state_s  n;
    gate_front_if fe ();
    logic         spRise;
    logic         spDone;
    logic         gateEff;
    logic         wrGate;
    logic         armReq;

    // ==========================================================
    // Address decode used by both read and write paths
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ==========================================================
    // Front end
    assign fe.gateSourceSelect = r.gateSourceSelect;
    assign fe.gatePolarity     = r.gatePolarity;
    assign fe.gateToggleMode   = r.gateToggleMode;
    assign fe.counterRunBit    = r.counterRunBit;

    gate_front u_front (
        .clk                     (clk),
        .rst_n                   (rst_n),
        .gatePin                 (gatePin),
        .otherTimerOverflow      (otherTimerOverflow),
        .comparatorASyncedOutput (comparatorASyncedOutput),
        .comparatorBSyncedOutput (comparatorBSyncedOutput),
        .fe                      (fe.front)
    );

    // ==========================================================
    // Next state
    always_comb begin
        n      = r;
        spDone = 1'b0;
        wrGate = wrStb && hit(addr, `TG_OFS_GATE);
        // Arming is honoured only when the same write keeps the mode on
        armReq = wrGate && wrData[`TG_BIT_GO] && wrData[`TG_BIT_SPM];

        // Configuration writes
        if (wrStb && hit(addr, `TG_OFS_CTRL)) begin
            n.counterRunBit = wrData[`TG_BIT_RUN];
        end
        if (wrGate) begin
            n.gateEnable          = wrData[`TG_BIT_GE];
            n.gatePolarity        = wrData[`TG_BIT_POL];
            n.gateToggleMode      = wrData[`TG_BIT_GTM];
            n.gateSinglePulseMode = wrData[`TG_BIT_SPM];
            n.gateSourceSelect    =
                wrData[`TG_BIT_GSS_MSB:`TG_BIT_GSS_LSB];
        end
        if (wrStb && hit(addr, `TG_OFS_IEN)) begin
            n.gateEventIrqEnable = wrData[`TG_BIT_FLAG];
        end

        // Single-pulse acquisition waits for a rising gate edge
        spRise    = fe.gateMid & ~r.prevMid;
        n.prevMid = fe.gateMid;
        case (r.phase)
            SP_IDLE: begin
                if (r.singlePulseAcquireStatus && spRise) begin
                    n.phase = SP_OPEN;
                end
            end
            SP_OPEN: begin
                if (!fe.gateMid) begin
                    n.phase                    = SP_IDLE;
                    n.singlePulseAcquireStatus = 1'b0;
                    spDone                     = 1'b1;
                end
            end
            default: n.phase = SP_IDLE;
        endcase

        // Software abort, then re-arm; a re-arm beats a completion
        if (wrGate && !wrData[`TG_BIT_GO]) begin
            n.singlePulseAcquireStatus = 1'b0;
            n.phase                    = SP_IDLE;
        end
        if (armReq) begin
            n.singlePulseAcquireStatus = 1'b1;
            n.phase                    = SP_IDLE;
        end
        if (!n.gateSinglePulseMode) begin
            n.singlePulseAcquireStatus = 1'b0;
            n.phase                    = SP_IDLE;
        end

        // Event flag: a set in the clearing cycle survives
        if (wrStb && hit(addr, `TG_OFS_CLR) && wrData[`TG_BIT_FLAG]) begin
            n.gateEventFlag = 1'b0;
        end
        if (spDone) begin
            n.gateEventFlag = 1'b1;
        end

        // Effective gate: in single-pulse mode only the admitted interval
        if (r.gateSinglePulseMode) begin
            gateEff = r.singlePulseAcquireStatus & fe.gateMid
                      & ((r.phase == SP_OPEN) | spRise);
        end else begin
            gateEff = fe.gateMid;
        end
        n.gateLevel   = gateEff;
        n.countEnable = r.counterRunBit
                        & (~r.gateEnable | gateEff);
        n.irq         = r.gateEventFlag & r.gateEventIrqEnable;

        // Read data stand for one cycle only; unmapped reads give zero
        n.rdData = `TG_BYTE_ZERO;
        if (rdStb) begin
            if (hit(addr, `TG_OFS_CTRL)) begin
                n.rdData[`TG_BIT_RUN] = r.counterRunBit;
            end else if (hit(addr, `TG_OFS_GATE)) begin
                n.rdData[`TG_BIT_GE]   = r.gateEnable;
                n.rdData[`TG_BIT_POL]  = r.gatePolarity;
                n.rdData[`TG_BIT_GTM]  = r.gateToggleMode;
                n.rdData[`TG_BIT_SPM]  = r.gateSinglePulseMode;
                n.rdData[`TG_BIT_GO]   = r.singlePulseAcquireStatus;
                n.rdData[`TG_BIT_GATE_LEVEL_STATUS] = r.gateLevel;
                n.rdData[`TG_BIT_GSS_MSB:`TG_BIT_GSS_LSB] =
                    r.gateSourceSelect;
            end else if (hit(addr, `TG_OFS_STAT)) begin
                n.rdData[`TG_BIT_FLAG] = r.gateEventFlag;
            end else if (hit(addr, `TG_OFS_IEN)) begin
                n.rdData[`TG_BIT_FLAG] = r.gateEventIrqEnable;
            end
        end
    end

    // ==========================================================
    // State register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flip-flops
    assign rdData      = r.rdData;
    assign countEnable = r.countEnable;
    assign irq         = r.irq;

    // ==========================================================
    // Checks
    property p_stop_blocks;
        @(posedge clk) disable iff (!rst_n)
        !r.counterRunBit |=> !countEnable;
    endproperty
    a_stop_blocks: assert property (p_stop_blocks)
        else $error("counting while stopped");

    property p_free_count;
        @(posedge clk) disable iff (!rst_n)
        (r.counterRunBit && !r.gateEnable) |=> countEnable;
    endproperty
    a_free_count: assert property (p_free_count)
        else $error("ungated timer not counting");

    property p_pol_high;
        @(posedge clk) disable iff (!rst_n)
        (r.counterRunBit && r.gateEnable && r.gatePolarity
         && !r.gateToggleMode && !r.gateSinglePulseMode
         && r.gateSourceSelect == `TG_GSS_PIN && gatePin) |=> countEnable;
    endproperty
    a_pol_high: assert property (p_pol_high)
        else $error("active-high gate did not count");

    property p_pol_low;
        @(posedge clk) disable iff (!rst_n)
        (r.counterRunBit && r.gateEnable && !r.gatePolarity
         && !r.gateToggleMode && !r.gateSinglePulseMode
         && r.gateSourceSelect == `TG_GSS_CMPA
         && comparatorASyncedOutput) |=> !countEnable;
    endproperty
    a_pol_low: assert property (p_pol_low)
        else $error("active-low gate counted while high");

    property p_pulse_done;
        @(posedge clk) disable iff (!rst_n)
        (r.phase == SP_OPEN && !fe.gateMid && !wrGate)
            |=> (!r.singlePulseAcquireStatus && r.gateEventFlag);
    endproperty
    a_pulse_done: assert property (p_pulse_done)
        else $error("pulse end did not clear status and set flag");

    property p_pulse_block;
        @(posedge clk) disable iff (!rst_n)
        (r.gateSinglePulseMode && !r.singlePulseAcquireStatus)
            |=> !r.gateLevel;
    endproperty
    a_pulse_block: assert property (p_pulse_block)
        else $error("gate admitted without arming");

    property p_arm_status;
        @(posedge clk) disable iff (!rst_n)
        armReq |=> r.singlePulseAcquireStatus;
    endproperty
    a_arm_status: assert property (p_arm_status)
        else $error("arming did not set acquisition status");

    property p_irq_level;
        @(posedge clk) disable iff (!rst_n)
        (r.gateEventFlag && r.gateEventIrqEnable) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("enabled event did not raise interrupt");

    property p_flag_sticky;
        @(posedge clk) disable iff (!rst_n)
        (r.gateEventFlag && !(wrStb && hit(addr, `TG_OFS_CLR)))
            |=> r.gateEventFlag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("event flag lost without a clear");

    // Gate level status must track the gate whatever gate enable says
    property p_level_free;
        @(posedge clk) disable iff (!rst_n)
        !r.gateSinglePulseMode |=> (r.gateLevel == $past(fe.gateMid));
    endproperty
    a_level_free: assert property (p_level_free)
        else $error("gate level status ignores the gate");

    property p_ce_gated;
        @(posedge clk) disable iff (!rst_n)
        (r.counterRunBit && r.gateEnable && !gateEff) |=> !countEnable;
    endproperty
    a_ce_gated: assert property (p_ce_gated)
        else $error("gated timer counted with the gate inactive");

    property p_spm_off_idle;
        @(posedge clk) disable iff (!rst_n)
        !r.gateSinglePulseMode
            |-> (r.phase == SP_IDLE && !r.singlePulseAcquireStatus);
    endproperty
    a_spm_off_idle: assert property (p_spm_off_idle)
        else $error("acquisition active with single-pulse mode off");

    property p_arm_refused;
        @(posedge clk) disable iff (!rst_n)
        (wrGate && wrData[`TG_BIT_GO] && !wrData[`TG_BIT_SPM])
            |=> !r.singlePulseAcquireStatus;
    endproperty
    a_arm_refused: assert property (p_arm_refused)
        else $error("arming accepted with single-pulse mode off");

    property p_open_armed;
        @(posedge clk) disable iff (!rst_n)
        (r.phase == SP_OPEN) |-> r.singlePulseAcquireStatus;
    endproperty
    a_open_armed: assert property (p_open_armed)
        else $error("admitted interval without acquisition status");

    // A pulse end in the clearing cycle must leave the flag set
    property p_flag_set_wins;
        @(posedge clk) disable iff (!rst_n)
        spDone |=> r.gateEventFlag;
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins)
        else $error("pulse end lost against a flag clear");

    property p_flag_clear;
        @(posedge clk) disable iff (!rst_n)
        (wrStb && hit(addr, `TG_OFS_CLR) && wrData[`TG_BIT_FLAG]
         && !spDone) |=> !r.gateEventFlag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("event flag survived a clear");

    property p_irq_off;
        @(posedge clk) disable iff (!rst_n)
        !(r.gateEventFlag && r.gateEventIrqEnable) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt raised without an enabled event");

endmodule : timer_gate_control

// [verif/tb_timer_gate_control.sv]
// Self-checking bench for the timer gate control block.
// Assumes the constants header is on the include path and the design
// files are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`include "timer_gate_defs.svh"
module tb_timer_gate_control;

    // ==========================================================
    // Signals and case table
    typedef struct packed {
        logic       run;
        logic [7:0] gcon;
        logic [3:0] src;
        logic       ce;
        logic       gate_level_status;
    } row_s;

    logic       clk;
    logic       rst_n;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
    logic [7:0] rdData;
    logic [3:0] src;
    logic       countEnable;
    logic       irq;
    logic [7:0] rd;
    logic [7:0] rdExp;
    // Gate register after reset: low polarity makes an idle low pin active
    localparam logic [7:0] gvalOnly = 8'h01 << `TG_BIT_GATE_LEVEL_STATUS;
    int         nMismatch;
    int         checkCount;
    int         cycleCount = 0;

    // Source bits: 0 pin, 1 overflow, 2 comparator A, 3 comparator B
    row_s rows [11] = '{
        '{1'b0, 8'hc0, 4'h1, 1'b0, 1'b1},
        '{1'b1, 8'h40, 4'h0, 1'b1, 1'b0},
        '{1'b1, 8'hc0, 4'h1, 1'b1, 1'b1},
        '{1'b1, 8'h80, 4'h1, 1'b0, 1'b0},
        '{1'b1, 8'h80, 4'h0, 1'b1, 1'b1},
        '{1'b1, 8'hc1, 4'h2, 1'b1, 1'b1},
        '{1'b1, 8'hc1, 4'hd, 1'b0, 1'b0},
        '{1'b1, 8'hc2, 4'h4, 1'b1, 1'b1},
        '{1'b1, 8'hc2, 4'hb, 1'b0, 1'b0},
        '{1'b1, 8'hc3, 4'h8, 1'b1, 1'b1},
        '{1'b1, 8'hc3, 4'h7, 1'b0, 1'b0}
    };

    timer_gate_control u_timer_gate_control (
        .clk                     (clk),
        .rst_n                   (rst_n),
        .addr                    (addr),
        .wrData                  (wrData),
        .wrStb                   (wrStb),
        .rdStb                   (rdStb),
        .rdData                  (rdData),
        .gatePin                 (src[0]),
        .otherTimerOverflow      (src[1]),
        .comparatorASyncedOutput (src[2]),
        .comparatorBSyncedOutput (src[3]),
        .countEnable             (countEnable),
        .irq                     (irq)
    );

    // ==========================================================
    // Clock and hang guard
    always #5 clk = ~clk;

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 4000) begin
            nMismatch++;
            results();
        end
    end

    // ==========================================================
    // Bus, settle and compare tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        d = rdData;
    endtask : rdReg

    // Gate path lags up to two edges (toggle mode); three keeps clear of the boundary
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic chkBit(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chkBit

    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chkByte

    // Drive the pin, let it settle, check the count enable
    task automatic pinCheck(input logic lvl, input logic exp);
        @(posedge clk);
        src[0] <= lvl;
        settle();
        chkBit(countEnable, exp);
    endtask : pinCheck

    task automatic results();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // ==========================================================
    // Main sequence
    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        addr       = 8'h00;
        wrData     = 8'h00;
        wrStb      = 1'b0;
        rdStb      = 1'b0;
        src        = 4'h0;
        nMismatch  = 0;
        checkCount = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chkBit(countEnable, 1'b0);
        chkBit(irq, 1'b0);
        // Every offset plus one unmapped reads zero, bar the gate level
        for (int i = 0; i < 6; i++) begin
            rdReg(8'(i * 4), rd);
            rdExp = (8'(i * 4) == `TG_OFS_GATE) ? gvalOnly : 8'h00;
            chkByte(rd, rdExp);
        end
        // Non-zero read first, so the drop back to zero is visible
        rdReg(`TG_OFS_GATE, rd);
        @(posedge clk);
        #1;
        chkByte(rdData, 8'h00);
        wr(8'h14, 8'hff);
        rdReg(`TG_OFS_CTRL, rd);
        chkByte(rd, 8'h00);
        $display("reset test done");

        // Ordinary gating cases from the table
        foreach (rows[i]) begin
            @(posedge clk);
            src <= rows[i].src;
            wr(`TG_OFS_CTRL, {7'h00, rows[i].run});
            wr(`TG_OFS_GATE, rows[i].gcon);
            settle();
            chkBit(countEnable, rows[i].ce);
            rdReg(`TG_OFS_GATE, rd);
            chkBit(rd[`TG_BIT_GATE_LEVEL_STATUS], rows[i].gate_level_status);
        end
        $display("table test done");

        // Toggle flip-flop: two rising edges per full count cycle
        @(posedge clk);
        src <= 4'h0;
        wr(`TG_OFS_GATE, 8'he0);
        settle();
        chkBit(countEnable, 1'b0);
        pinCheck(1'b1, 1'b1);
        pinCheck(1'b0, 1'b1);
        pinCheck(1'b1, 1'b0);
        pinCheck(1'b0, 1'b0);
        pinCheck(1'b1, 1'b1);
        pinCheck(1'b0, 1'b1);
        // Flip-flop is high now; leaving toggle mode must bypass it
        wr(`TG_OFS_GATE, 8'hc0);
        settle();
        chkBit(countEnable, 1'b0);
        wr(`TG_OFS_GATE, 8'he0);
        settle();
        chkBit(countEnable, 1'b0);
        pinCheck(1'b1, 1'b1);
        pinCheck(1'b0, 1'b1);
        wr(`TG_OFS_CTRL, 8'h00);
        settle();
        chkBit(countEnable, 1'b0);
        wr(`TG_OFS_CTRL, 8'h01);
        settle();
        chkBit(countEnable, 1'b0);
        $display("toggle test done");

        // Single pulse: arm, one interval, flag, mask, clear, re-arm
        wr(`TG_OFS_IEN, 8'h01);
        wr(`TG_OFS_GATE, 8'hc8);
        rdReg(`TG_OFS_GATE, rd);
        chkBit(rd[`TG_BIT_GO], 1'b0);
        wr(`TG_OFS_GATE, 8'hd8);
        rdReg(`TG_OFS_GATE, rd);
        chkBit(rd[`TG_BIT_GO], 1'b1);
        settle();
        chkBit(countEnable, 1'b0);
        pinCheck(1'b1, 1'b1);
        pinCheck(1'b0, 1'b0);
        rdReg(`TG_OFS_GATE, rd);
        chkBit(rd[`TG_BIT_GO], 1'b0);
        rdReg(`TG_OFS_STAT, rd);
        chkByte(rd, 8'h01);
        chkBit(irq, 1'b1);
        pinCheck(1'b1, 1'b0);
        pinCheck(1'b0, 1'b0);
        wr(`TG_OFS_IEN, 8'h00);
        settle();
        chkBit(irq, 1'b0);
        wr(`TG_OFS_CLR, 8'h01);
        rdReg(`TG_OFS_STAT, rd);
        chkByte(rd, 8'h00);
        wr(`TG_OFS_IEN, 8'h01);
        settle();
        chkBit(irq, 1'b0);
        wr(`TG_OFS_GATE, 8'hd8);
        pinCheck(1'b1, 1'b1);
        pinCheck(1'b0, 1'b0);
        chkBit(irq, 1'b1);
        $display("single pulse test done");

        // Reset in mid-run returns outputs and registers to zero
        wr(`TG_OFS_GATE, 8'hc0);
        pinCheck(1'b1, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chkBit(countEnable, 1'b0);
        chkBit(irq, 1'b0);
        rdReg(`TG_OFS_GATE, rd);
        // Pin still high, polarity back to low: gate level reads zero
        chkByte(rd, 8'h00);
        $display("second reset test done");
        results();
    end

endmodule : tb_timer_gate_control
